/* File: rtl/sdci_top.sv */
// Purpose: Serial command front end of a 12-bit multiplying DAC
// Assumes: Link pins are asynchronous to clk_sys_i, clock well below 25 MHz
// Notes: Link clock is sampled; its edges become one-cycle enables
`timescale 1ns/1ns
`default_nettype none
module sdci_top
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial link pins
  input wire logic frame_select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  // Converter side
  output logic [11:0] dac_code_o,
  output logic dac_update_o,
  // Status
  output logic chain_mode_o,
  output logic rising_edge_mode_o
);
  typedef enum logic [1:0] {SDCI_IDLE, SDCI_SHIFT, SDCI_DONE} sdci_state_e;

  sdci_shift_if sh ();

  sdci_shifter u_shifter
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sh(sh)
  );

  logic [1:0] sel_sync_reg;
  logic [1:0] clk_sync_reg;
  logic [1:0] din_sync_reg;
  logic sel_d_reg;
  logic clk_d_reg;
  logic [11:0] dac_reg;
  logic update_reg;
  logic chain_reg;
  logic rise_reg;
  logic readback_reg;
  logic sdo_reg;
  sdci_state_e state_reg;

  logic sel_n;
  logic sclk;
  logic rise_ev;
  logic fall_ev;
  logic sel_fall;
  logic sel_rise;
  logic active_ev;
  logic inactive_ev;
  logic exec_now;
  logic [3:0] cmd;
  logic [11:0] data;

  // Two-stage synchronisers on every pin
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sel_sync_reg <= 2'h3;
      // Idle high, as in the default falling mode
      clk_sync_reg <= 2'h3;
      din_sync_reg <= 2'h0;
      sel_d_reg <= 1'b1;
      clk_d_reg <= 1'b1;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[0], frame_select_n_i};
      clk_sync_reg <= {clk_sync_reg[0], serial_clk_i};
      din_sync_reg <= {din_sync_reg[0], serial_in_i};
      sel_d_reg <= sel_sync_reg[1];
      clk_d_reg <= clk_sync_reg[1];
    end
  end

  assign sel_n = sel_sync_reg[1];
  assign sclk = clk_sync_reg[1];
  assign rise_ev = sclk && !clk_d_reg;
  assign fall_ev = !sclk && clk_d_reg;
  assign sel_fall = !sel_n && sel_d_reg;
  assign sel_rise = sel_n && !sel_d_reg;
  assign active_ev = rise_reg ? rise_ev : fall_ev;
  assign inactive_ev = rise_reg ? fall_ev : rise_ev;

  assign cmd = sh.word[sdci_pkg::CMD_MSB:sdci_pkg::CMD_LSB];
  assign data = sh.word[sdci_pkg::DATA_MSB:0];

  assign sh.shift_en = !sel_n && !sel_fall && active_ev
    && state_reg != SDCI_DONE;
  assign sh.bit_in = din_sync_reg[1];

  // chain mode waits for select rise
  assign exec_now = chain_reg ? (sel_rise && state_reg != SDCI_IDLE)
    : (state_reg == SDCI_DONE && sh.count == sdci_pkg::EDGE_COUNT_FULL);

  assign sh.clear = sel_fall || (sel_rise && !chain_reg
    && sh.count != sdci_pkg::EDGE_COUNT_FULL);

  // readback loads the DAC code into the shifter
  assign sh.load_en = readback_reg && sel_fall;
  assign sh.load_word = {sdci_pkg::CMD_NOP, dac_reg};

  // Frame tracking
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= SDCI_IDLE;
    end
    else
    begin
      case (state_reg)
        SDCI_IDLE:
        begin
          if (sh.shift_en)
          begin
            state_reg <= SDCI_SHIFT;
          end
        end
        SDCI_SHIFT:
        begin
          if (sel_n)
          begin
            state_reg <= SDCI_IDLE;
          end
          else if (!chain_reg && sh.count == sdci_pkg::EDGE_COUNT_FULL)
          begin
            state_reg <= SDCI_DONE;
          end
        end
        SDCI_DONE:
        begin
          state_reg <= SDCI_IDLE;
        end
        default:
        begin
          state_reg <= SDCI_IDLE;
        end
      endcase
    end
  end

  // code 0000 and reserved codes fall to default
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dac_reg <= sdci_pkg::DAC_ZERO;
      update_reg <= 1'b0;
      chain_reg <= 1'b1;
      rise_reg <= 1'b0;
    end
    else
    begin
      update_reg <= 1'b0;
      if (exec_now)
      begin
        case (cmd)
          // load and data used only here
          sdci_pkg::CMD_LOAD:
          begin
            dac_reg <= data;
            update_reg <= 1'b1;
          end
          sdci_pkg::CMD_CHAIN_OFF:
          begin
            chain_reg <= 1'b0;
          end
          sdci_pkg::CMD_RISE_EDGE:
          begin
            rise_reg <= 1'b1;
          end
          sdci_pkg::CMD_CLR_ZERO:
          begin
            dac_reg <= sdci_pkg::DAC_ZERO;
            update_reg <= 1'b1;
          end
          sdci_pkg::CMD_CLR_MID:
          begin
            dac_reg <= sdci_pkg::DAC_MID;
            update_reg <= 1'b1;
          end
          default:
          begin
            dac_reg <= dac_reg;
          end
        endcase
      end
    end
  end

  // readback armed for the next frame
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      readback_reg <= 1'b0;
    end
    else if (exec_now && cmd == sdci_pkg::CMD_READBACK)
    begin
      readback_reg <= 1'b1;
    end
    else if (sh.load_en)
    begin
      readback_reg <= 1'b0;
    end
  end

  // MSB changes on the inactive edge
  // inactive edge before first shift ignored by count gate
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sdo_reg <= 1'b0;
    end
    else if (sh.load_en
      || (inactive_ev && !sel_n && !sel_fall && sh.count != 5'h00))
    begin
      sdo_reg <= sh.load_en ? 1'b0 : sh.word[sdci_pkg::CMD_MSB];
    end
  end

  assign serial_out_o = sdo_reg;
  assign dac_code_o = dac_reg;
  assign dac_update_o = update_reg;
  assign chain_mode_o = chain_reg;
  assign rising_edge_mode_o = rise_reg;
endmodule
`default_nettype wire

/* File: rtl/sdci_pkg.sv */
// Purpose: Constants for the serial DAC command interface
// Assumes: 16-bit frames, MSB first
// Notes: Used by the top only; the shift register module uses literal widths
package sdci_pkg;
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int DATA_MSB = 11;
  localparam logic [4:0] EDGE_COUNT_FULL = 5'h10;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_LOAD = 4'h1;
  localparam logic [3:0] CMD_READBACK = 4'h2;
  localparam logic [3:0] CMD_CHAIN_OFF = 4'h9;
  localparam logic [3:0] CMD_RISE_EDGE = 4'ha;
  localparam logic [3:0] CMD_CLR_ZERO = 4'hb;
  localparam logic [3:0] CMD_CLR_MID = 4'hc;
  localparam logic [11:0] DAC_ZERO = 12'h000;
  localparam logic [11:0] DAC_MID = 12'h800;
endpackage

/* File: rtl/sdci_shift_if.sv */
// Purpose: Carrier between the top and the shift register
// Assumes: One system clock
// Notes: Control travels to the shifter, word and count come back
`timescale 1ns/1ns
`default_nettype none
interface sdci_shift_if;
  logic shift_en;
  logic bit_in;
  logic clear;
  logic load_en;
  logic [15:0] load_word;
  logic [15:0] word;
  logic [4:0] count;
  modport ctrl (output shift_en, bit_in, clear, load_en, load_word,
    input word, count);
  modport shifter (input shift_en, bit_in, clear, load_en, load_word,
    output word, count);
endinterface
`default_nettype wire

/* File: rtl/sdci_shifter.sv */
// Purpose: 16-bit input shift register with active edge count
// Assumes: Strobes are one-cycle pulses on clk_sys_i
// Notes: Load has priority over clear, so readback survives frame start
`timescale 1ns/1ns
`default_nettype none
module sdci_shifter
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  sdci_shift_if.shifter sh
);
  logic [15:0] word_reg;
  logic [4:0] count_reg;

  assign sh.word = word_reg;
  assign sh.count = count_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_reg <= 16'h0000;
    end
    else if (sh.load_en)
    begin
      word_reg <= sh.load_word;
    end
    else if (sh.clear)
    begin
      word_reg <= 16'h0000;
    end
    else if (sh.shift_en)
    begin
      word_reg <= {word_reg[14:0], sh.bit_in};
    end
  end

  // Saturating count of active edges in the frame
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_reg <= 5'h00;
    end
    else if (sh.clear)
    begin
      count_reg <= 5'h00;
    end
    else if (sh.shift_en && count_reg != 5'h1f)
    begin
      count_reg <= count_reg + 5'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verif/sdci_host.sv */
// Purpose: Host serial master model
// Assumes: Phases of 80 ns
// Notes: Released data turns to its inverse
`timescale 1ns/1ns
`default_nettype none
module sdci_host
(
  // Link pins
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic [15:0] rx;
  initial {sel_n_o, sclk_o, sdi_o} = 3'b110;
  task automatic shift(input logic [31:0] w, input int n, input logic re);
    sclk_o = ~re;
    #200 sel_n_o = 1'b0;
    // Data turns over mid-phase, so a wrong edge reads the inverse
    for (int i = n - 1; i >= 0; i--)
    begin
      #40 sdi_o = w[i];
      #30 rx = {rx[14:0], sdo_i};
      #10 sclk_o = re;
      #40 sdi_o = ~w[i];
      #40 sclk_o = ~re;
    end
    #160;
  endtask
  task automatic finish();
    sel_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: verif/sdci_top_assertions.sv */
// Purpose: Port checks of the front end
// Assumes: One clock
// Notes: Bound below
`timescale 1ns/1ns
`default_nettype none
module sdci_top_assertions
(
  // Watched ports
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic frame_select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic serial_out_o,
  input wire logic [11:0] dac_code_o,
  input wire logic dac_update_o,
  input wire logic chain_mode_o,
  input wire logic rising_edge_mode_o
);
  logic [3:0] st_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Cycles since select moved
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      st_cnt <= 4'h0;
    else
      st_cnt <= $changed(frame_select_n_i) ? 4'h0
        : st_cnt + {3'h0, st_cnt != 4'hf};
  upd_one_a: assert property (dac_update_o |=> !dac_update_o)
    else $error("long strobe");
  code_cause_a: assert property ($changed(dac_code_o) |->
    dac_update_o || $past(dac_update_o)) else $error("silent change");
  idle_hold_a: assert property (frame_select_n_i && st_cnt > 4'h9
    |-> !dac_update_o) else $error("idle update");
  chain_wait_a: assert property (chain_mode_o && !frame_select_n_i
    && st_cnt > 4'h9 |-> !dac_update_o) else $error("early exec");
  alone_exec_a: assert property (dac_update_o && !chain_mode_o |->
    !frame_select_n_i) else $error("late exec");
  chain_keep_a: assert property (!chain_mode_o |=> !chain_mode_o)
    else $error("chain back");
  edge_keep_a: assert property (rising_edge_mode_o |=>
    rising_edge_mode_o) else $error("edge back");
  out_idle_a: assert property (frame_select_n_i && st_cnt > 4'h9
    |=> $stable(serial_out_o)) else $error("out moved");
  cover property (dac_update_o && chain_mode_o);
  cover property (dac_update_o && !chain_mode_o);
  cover property ($rose(rising_edge_mode_o));
endmodule
bind sdci_top sdci_top_assertions chk_u (.*);
`default_nettype wire

/* File: verif/sdci_top_tb.sv */
// Purpose: Bench of the front end
// Assumes: Host model drives the link
// Notes: Fixed seed
`timescale 1ns/1ns
`default_nettype none
module sdci_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sel_n, sclk, sdi, serial_out, upd, cm, rm;
  logic [11:0] dac, old, exp, mdl;
  logic mch, mre;
  int pulses = 0;
  int errors = 0;
  int compares = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  sdci_top dut_u (.clk_sys_i, .rst_i, .frame_select_n_i(sel_n),
    .serial_clk_i(sclk), .serial_in_i(sdi), .serial_out_o(serial_out),
    .dac_code_o(dac), .dac_update_o(upd), .chain_mode_o(cm),
    .rising_edge_mode_o(rm));
  sdci_host hm (.sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(serial_out));
  // Update strobes, counted away from the launching edge
  always @(negedge clk_sys_i)
    if (upd === 1'b1)
      pulses++;
  task automatic model_reset();
    mdl = 12'h000;
    mch = 1'b1;
    mre = 1'b0;
  endtask
  task automatic chk_code(input logic [11:0] g, input logic [11:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_code({11'h0, g}, {11'h0, e});
  endtask
  function automatic logic [11:0] nxt(input logic [15:0] v);
    case (v[15:12])
      4'h1: return v[11:0];
      4'hb: return 12'h000;
      4'hc: return 12'h800;
      default: return mdl;
    endcase
  endfunction
  task automatic check_defaults();
    chk_code(dac, 12'h000);
    chk_bit(cm, 1'b1);
    chk_bit(rm, 1'b0);
  endtask
  task automatic op(input logic [15:0] v);
    int p0;
    logic want;
    p0 = pulses;
    want = v[15:12] inside {4'h1, 4'hb, 4'hc};
    old = mdl;
    exp = nxt(v);
    hm.shift({16'h0, v}, 16, mre);
    chk_code(dac, mch ? old : exp);
    hm.finish();
    chk_code(dac, exp);
    chk_code(12'(pulses - p0), {11'h0, want});
    mdl = exp;
    if (v[15:12] == 4'h9)
      mch = 1'b0;
    if (v[15:12] == 4'ha)
      mre = 1'b1;
    $display("test %h done", v);
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    exp = 12'($urandom(79922));
    model_reset();
    repeat (4) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    #80 check_defaults();
    hm.shift({16'h1fff, 4'h1, exp}, 32, mre);
    chk_code(dac, 12'h000);
    chk_code(hm.rx[11:0], 12'hfff);
    hm.finish();
    chk_code(dac, exp);
    mdl = exp;
    $display("test chain done");
    for (int k = 0; k < 16; k++)
      if (!(k inside {1, 9, 10}))
        op({4'(k), 12'($urandom)});
    op(16'h2000);
    op(16'h0000);
    chk_code(hm.rx[11:0], 12'h800);
    op({4'h9, 12'($urandom)});
    chk_bit(cm, 1'b0);
    hm.shift(32'h1fff, 10, mre);
    hm.finish();
    chk_code(dac, mdl);
    chk_bit(cm, 1'b0);
    $display("test abort done");
    op({4'ha, 12'($urandom)});
    chk_bit(rm, 1'b1);
    repeat (4)
      op({4'h1, 12'($urandom)});
    @(posedge clk_sys_i);
    #1 rst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    model_reset();
    #80 check_defaults();
    op({4'h1, 12'($urandom)});
    $display("test reset done");
    wrap_up();
  end
  initial
  begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
